// ===== uie_pkg.sv
// Package: register map, field positions, reset values and bus codes of the
// host interrupt-enable block.
// Assumes word-aligned AXI4-Lite access with 32-bit data.
package uie_pkg;

  // Byte offsets of the registers
  localparam logic [7:0] OFF_COMMAND     = 8'h8c;
  localparam logic [7:0] OFF_STATUS      = 8'h90;
  localparam logic [7:0] OFF_ENABLE      = 8'h94;
  localparam logic [7:0] OFF_FRAME_INDEX = 8'h98;

  // Field positions
  localparam int BIT_WRAP = 3;
  localparam int BIT_PORT = 2;
  localparam int SIZE_HI  = 3;
  localparam int SIZE_LO  = 2;

  // Reset values
  localparam logic [3:2] RST_ENABLE = 2'h0;
  localparam logic [3:2] RST_STATUS = 2'h0;
  localparam logic [3:2] RST_SIZE   = 2'h0;

  // Frame index layout
  localparam int FRAME_INDEX_W    = 14;
  localparam int LIST_TOP_DEFAULT = 12;
  localparam logic [1:0] SIZE_RESERVED = 2'h3;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ===== uie_frame_index.sv
// Frame index counter with frame-list wrap detection.
// Assumes microframe_tick is a one-cycle pulse on aclk.
`timescale 1ns/1ps
`default_nettype none

module uie_frame_index
  import uie_pkg::*;
#(
  parameter int INDEX_W = FRAME_INDEX_W
)
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               microframe_tick,
  input  wire logic [1:0]         frame_list_size,
  output logic      [INDEX_W-1:0] frame_index,
  output logic                    frame_list_wrap
);

  typedef struct packed {
    logic [INDEX_W-1:0] index;
    logic               wrap;
  } uie_fi_state_t;

  uie_fi_state_t q;
  uie_fi_state_t n;

  // Bits of the index that address the frame list
  function automatic logic [INDEX_W-1:0] list_mask(input logic [1:0] size);
    int top;
    top = LIST_TOP_DEFAULT;
    if (size != SIZE_RESERVED)
    begin
      top = LIST_TOP_DEFAULT - int'(size);
    end
    list_mask = INDEX_W'((64'h1 << (top + 1)) - 64'h1);
  endfunction

  always_comb
  begin
    n = q;
    n.wrap = 1'b0;
    if (microframe_tick)
    begin
      n.index = q.index + INDEX_W'(1);
      if ((q.index | ~list_mask(frame_list_size)) == '1) // [R8]
      begin
        n.wrap = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  assign frame_index     = q.index;
  assign frame_list_wrap = q.wrap;

  chk_wrap_at_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    frame_list_wrap |-> (frame_index & list_mask($past(frame_list_size))) == '0)
    else $error("wrap pulse without list index at zero");

endmodule
`default_nettype wire

// ===== uie_host_irq.sv
// Host interrupt-enable block: status flags, enable register, interrupt level,
// frame-list size setting and frame index, all behind an AXI4-Lite slave.
// Assumes port change bits and resume pulse come from logic on aclk.
//
// Behaviour
// R1: Enable register at 94h, 32-bit RW, reset zero, only bits 3 and 2 used.
// R2: Rollover enable bit 3 with wrap flag set raises the interrupt request.
// R3: Clearing the wrap flag acknowledges it and withdraws that interrupt cause.
// R4: Port-change enable bit 2 with port flag set raises the interrupt request.
// R5: Clearing the port flag acknowledges it and withdraws that interrupt cause.
// R6: Software writes zero into every reserved bit of the enable register.
// R7: Status flags clear only on written one; written zero leaves them alone.
// R8: Wrap flag sets when frame list index wraps; size setting picks maximum.
// R9: Port flag sets on rising port change bit or resume on suspended port.
// R10: Interrupt is OR of enabled flags, held until all are cleared or disabled.
`timescale 1ns/1ps
`default_nettype none

module uie_host_irq
  import uie_pkg::*;
#(
  parameter int ADDR_W    = 8,
  parameter int NUM_PORTS = 2
)
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 microframe_tick,
  input  wire logic [NUM_PORTS-1:0] port_change_bits,
  input  wire logic                 resume_jk,
  output logic                      irq
);

  typedef struct packed {
    logic                 aw_got;
    logic [ADDR_W-1:0]    aw_addr;
    logic                 w_got;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic [3:2]           enable;
    logic [3:2]           status;
    logic [3:2]           list_size;
    logic [NUM_PORTS-1:0] port_prev;
  } uie_state_t;

  uie_state_t                 q;
  uie_state_t                 n;
  logic [FRAME_INDEX_W-1:0]   frame_index;
  logic                       frame_list_wrap;
  logic                       wr_commit;
  logic                       wr_low;
  logic                       wr_status;
  logic                       wr_enable;
  logic                       wr_command;
  logic                       port_rise;
  logic [3:2]                 set_bits;
  logic [3:2]                 clr_bits;

  // Word address match
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    addr_is = (a >> 2) == (ADDR_W'(off) >> 2);
  endfunction

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = addr_is(a, OFF_COMMAND) || addr_is(a, OFF_STATUS) ||
                  addr_is(a, OFF_ENABLE) || addr_is(a, OFF_FRAME_INDEX);
  endfunction

  // Read mux: response code above data
  function automatic logic [33:0] read_word(input logic [ADDR_W-1:0]        a,
                                            input logic [3:2]               en,
                                            input logic [3:2]               sts,
                                            input logic [3:2]               size,
                                            input logic [FRAME_INDEX_W-1:0] fi);
    logic [31:0] d;
    logic [1:0]  r;
    d = '0;
    r = RESP_OKAY;
    if (addr_is(a, OFF_ENABLE))
    begin
      d[3:2] = en; // [R1]
    end
    else if (addr_is(a, OFF_STATUS))
    begin
      d[3:2] = sts;
    end
    else if (addr_is(a, OFF_COMMAND))
    begin
      d[SIZE_HI:SIZE_LO] = size;
    end
    else if (addr_is(a, OFF_FRAME_INDEX))
    begin
      d[FRAME_INDEX_W-1:0] = fi;
    end
    else
    begin
      r = RESP_DECERR;
    end
    read_word = {r, d};
  endfunction

  uie_frame_index #(
    .INDEX_W (FRAME_INDEX_W)
  ) u_frame_index (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .microframe_tick (microframe_tick),
    .frame_list_size (q.list_size),
    .frame_index     (frame_index),
    .frame_list_wrap (frame_list_wrap)
  );

  // Write commits once address and data are both held
  assign wr_commit  = q.aw_got && q.w_got;
  assign wr_low     = wr_commit && q.w_strb[0];
  assign wr_status  = wr_low && addr_is(q.aw_addr, OFF_STATUS);
  assign wr_enable  = wr_low && addr_is(q.aw_addr, OFF_ENABLE);
  assign wr_command = wr_low && addr_is(q.aw_addr, OFF_COMMAND);

  // Flag sources
  assign port_rise = (|(port_change_bits & ~q.port_prev)) || resume_jk; // [R9]
  assign set_bits  = {frame_list_wrap, port_rise}; // [R8] [R9]
  assign clr_bits  = wr_status ? q.w_data[3:2] : 2'h0; // [R7]

  always_comb
  begin
    n = q;
    n.port_prev = port_change_bits;
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.aw_got  = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.w_got  = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
    begin
      n.bvalid = 1'b0;
    end
    if (wr_commit)
    begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = addr_mapped(q.aw_addr) ? RESP_OKAY : RESP_DECERR;
    end
    if (wr_enable)
    begin
      n.enable = q.w_data[3:2]; // [R1]
    end
    if (wr_command)
    begin
      n.list_size = q.w_data[SIZE_HI:SIZE_LO]; // [R8]
    end
    // Set wins over a clear in the same cycle
    n.status = (q.status & ~clr_bits) | set_bits; // [R3] [R5] [R7]
    if (q.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      n.rvalid = 1'b1;
      {n.rresp, n.rdata} = read_word(s_axi_araddr, q.enable, q.status, q.list_size,
                                     frame_index);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q           <= '0;
      q.enable    <= RST_ENABLE;
      q.status    <= RST_STATUS;
      q.list_size <= RST_SIZE;
    end
    else
    begin
      q <= n;
    end
  end

  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready  = !q.w_got && !q.bvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

  // Level request from enabled flags
  assign irq = |(q.status & q.enable); // [R2] [R4] [R10]

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_wrap_ack;
    wr_status && q.w_data[BIT_WRAP] && !frame_list_wrap;
  endsequence

  sequence seq_port_ack;
    wr_status && q.w_data[BIT_PORT] && !port_rise;
  endsequence

  sequence seq_enable_read;
    s_axi_arvalid && s_axi_arready && addr_is(s_axi_araddr, OFF_ENABLE);
  endsequence

  chk_enable_reset: assert property ($rose(aresetn) |-> q.enable == RST_ENABLE && !irq) // [R1]
    else $error("enable not zero after reset");

  chk_enable_reserved: assert property (seq_enable_read |=> (s_axi_rdata & ~32'h0000000c) == '0) // [R1]
    else $error("reserved enable bits read nonzero");

  chk_wrap_irq: assert property (q.status[BIT_WRAP] && q.enable[BIT_WRAP] |-> irq) // [R2]
    else $error("rollover cause without interrupt");

  chk_wrap_ack: assert property ( // [R3]
    seq_wrap_ack ##1 !(q.status[BIT_PORT] && q.enable[BIT_PORT])
    |-> !q.status[BIT_WRAP] && !irq)
    else $error("rollover acknowledge did not withdraw cause");

  chk_port_irq: assert property (q.status[BIT_PORT] && q.enable[BIT_PORT] |-> irq) // [R4]
    else $error("port change cause without interrupt");

  chk_port_ack: assert property ( // [R5]
    seq_port_ack ##1 !(q.status[BIT_WRAP] && q.enable[BIT_WRAP])
    |-> !q.status[BIT_PORT] && !irq)
    else $error("port change acknowledge did not withdraw cause");

  chk_zero_keeps: assert property ( // [R7]
    q.status[BIT_WRAP] && !(wr_status && q.w_data[BIT_WRAP]) |=> q.status[BIT_WRAP])
    else $error("wrap flag lost without written one");

  chk_port_keeps: assert property ( // [R7]
    q.status[BIT_PORT] && !(wr_status && q.w_data[BIT_PORT]) |=> q.status[BIT_PORT])
    else $error("port flag lost without written one");

  chk_wrap_sets: assert property (frame_list_wrap |=> q.status[BIT_WRAP]) // [R8]
    else $error("wrap did not set flag");

  chk_change_sets: assert property (port_rise |=> q.status[BIT_PORT]) // [R9]
    else $error("port change did not set flag");

  chk_irq_holds: assert property (irq && !wr_status && !wr_enable |=> irq) // [R10]
    else $error("interrupt dropped without clear or disable");

  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> wr_commit ##1 s_axi_bvalid && !wr_commit)
    else $error("write answer not two cycles after handshake");

  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) // [R1]
    else $error("read answer not one cycle after handshake");

  chk_enable_write: assert property (wr_enable |=> q.enable == $past(q.w_data[3:2])) // [R1]
    else $error("enable write not stored");

  chk_enable_only: assert property (!wr_enable |=> q.enable == $past(q.enable)) // [R1]
    else $error("enable changed without a write");

  chk_size_write: assert property ( // [R8]
    wr_command |=> q.list_size == $past(q.w_data[SIZE_HI:SIZE_LO]))
    else $error("frame list size write not stored");

endmodule
`default_nettype wire

// ===== uie_host_irq_tb.sv
// Testbench: AXI4-Lite register tests of the host interrupt-enable block.
// Assumes the block's defaults: 8-bit addresses, two port change inputs.
`timescale 1ns/1ps
`default_nettype none

module uie_host_irq_tb
  import uie_pkg::*;
;

  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, tick, resume;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, ports;
  int          failures = 0;
  int          checks = 0;
  int          cycles = 0;

  uie_host_irq dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .microframe_tick(tick), .port_change_bits(ports), .resume_jk(resume), .irq(irq)
  );

  initial
  begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      end_sim();
    end
  end

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_irq(input logic exp);
    cmp32({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    cmp32({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    cmp32(rdata, ed);
    cmp32({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      tick <= 1'b1;
      @(posedge aclk);
      tick <= 1'b0;
    end
    repeat (3) @(posedge aclk);
  endtask

  initial
  begin
    aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    tick = 0; resume = 0; ports = 2'h0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, byte lane, unmapped place
    rd(OFF_ENABLE, 32'h0, RESP_OKAY);
    rd(OFF_STATUS, 32'h0, RESP_OKAY);
    cmp_irq(1'b0);
    wr(OFF_ENABLE, 32'h0000000c, RESP_OKAY);
    rd(OFF_ENABLE, 32'h0000000c, RESP_OKAY);
    wr(OFF_ENABLE, 32'h0, RESP_OKAY);
    rd(OFF_ENABLE, 32'h0, RESP_OKAY);
    wstrb <= 4'he;
    wr(OFF_ENABLE, 32'h0000000c, RESP_OKAY);
    wstrb <= 4'hf;
    rd(OFF_ENABLE, 32'h0, RESP_OKAY);
    wr(8'hf0, 32'h0, RESP_DECERR);
    rd(8'hf0, 32'h0, RESP_DECERR);
    $display("test 1 done");
    // Port change flag, masked then enabled, cleared
    @(posedge aclk);
    ports <= 2'h1;
    repeat (3) @(posedge aclk);
    rd(OFF_STATUS, 32'h4, RESP_OKAY);
    cmp_irq(1'b0);
    wr(OFF_ENABLE, 32'h4, RESP_OKAY);
    cmp_irq(1'b1);
    wr(OFF_STATUS, 32'h0, RESP_OKAY);
    rd(OFF_STATUS, 32'h4, RESP_OKAY);
    wr(OFF_STATUS, 32'h4, RESP_OKAY);
    rd(OFF_STATUS, 32'h0, RESP_OKAY);
    cmp_irq(1'b0);
    ports <= 2'h0;
    resume <= 1'b1;
    @(posedge aclk);
    resume <= 1'b0;
    repeat (2) @(posedge aclk);
    cmp_irq(1'b1);
    $display("test 2 done");
    // Frame list wrap at 2048 entries
    wr(OFF_COMMAND, 32'h8, RESP_OKAY);
    rd(OFF_COMMAND, 32'h8, RESP_OKAY);
    ticks(2047);
    rd(OFF_FRAME_INDEX, 32'h7ff, RESP_OKAY);
    rd(OFF_STATUS, 32'h4, RESP_OKAY);
    ticks(1);
    rd(OFF_STATUS, 32'hc, RESP_OKAY);
    rd(OFF_FRAME_INDEX, 32'h800, RESP_OKAY);
    wr(OFF_ENABLE, 32'h8, RESP_OKAY);
    cmp_irq(1'b1);
    wr(OFF_ENABLE, 32'hc, RESP_OKAY);
    wr(OFF_STATUS, 32'h8, RESP_OKAY);
    cmp_irq(1'b1);
    wr(OFF_ENABLE, 32'h8, RESP_OKAY);
    cmp_irq(1'b0);
    wr(OFF_STATUS, 32'h4, RESP_OKAY);
    rd(OFF_STATUS, 32'h0, RESP_OKAY);
    $display("test 3 done");
    end_sim();
  end
endmodule

`default_nettype wire
